// ### core/evt_defines.svh
`ifndef EVT_DEFINES_SVH
`define EVT_DEFINES_SVH
// Overview of operation
// R1: five modes, continuous default ignores gate
// R2: one selectable polarity for all contacts
// R3: sample-on-fall captures at logical gate fall
// R4: freeze holds display, ignores gate/startup/zero
// R5: gate rising during error voids that capture
// R6: window modes stop on error, window voided
// R7: clear discards data, blocks measuring, ignores gate
// R8: output follows display, zero without data
// R9: peak mode: window maximum becomes result
// R10: valley mode: window minimum becomes result
// R11: peak-to-peak: window maximum minus minimum
// R12: indicator lit whenever gate asserted
// R13: freeze ignored while clear asserted
// R14: one-shot pulse per measurement, not continuous
// R15: zero request works despite lockout or views
// R16: zero rejected on error, freeze, no data
// R17: clear keeps zero reference, clears max/min
// R18: sample-on-fall updates max/min at gate fall
// R19: programmable on/off gate delays, 0..999.9 s
// R20: new gate edge abandons pending delayed event
// R21: continuous bypasses both delays, fall-mode off
// R22: controller keeps gate longer than on delay
// R23: startup input pauses delay count for period
// R24: contacts synchronised, delays in 0.1 s ticks

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define EVT_OFS_CTRL 12'h000
`define EVT_OFS_ON_DLY 12'h004
`define EVT_OFS_OFF_DLY 12'h008
`define EVT_OFS_STARTUP 12'h00c
`define EVT_OFS_STATUS 12'h010
`define EVT_OFS_RESULT 12'h014
`define EVT_OFS_MAX 12'h018
`define EVT_OFS_MIN 12'h01c
`define EVT_OFS_ZERO_REF 12'h020

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define EVT_CTRL_MODE_LSB 0
`define EVT_CTRL_MODE_MSB 2
`define EVT_CTRL_NEG_BIT 3
`define EVT_ST_HAS_DATA 0
`define EVT_ST_GATE 1
`define EVT_ST_ZERO_ON 2
`define EVT_ST_FREEZE 3
`define EVT_ST_CLEAR 4
`define EVT_ST_SCALE_ERR 5
`define EVT_ST_PENDING 6
`define EVT_ST_PAUSE 7

// ----------------------------------------------------------------
// reset values and limits (in 0.1 s ticks)
// ----------------------------------------------------------------
`define EVT_NEG_RST 1'b0
`define EVT_DLY_RST 14'h0000
`define EVT_STARTUP_RST 10'h000
`define EVT_DLY_MAX 14'd9999
`define EVT_STARTUP_MAX 10'd999

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define EVT_TICK_NS 100000000
`define EVT_CLK_NS 4
`define EVT_TICK_CYCLES (`EVT_TICK_NS / `EVT_CLK_NS)

`endif

// ### core/evt_pkg.sv
package evt_pkg;

	// ----------------------------------------------------------------
	// trigger modes
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		CONTINUOUS_MODE,
		SAMPLE_ON_FALL_MODE,
		PEAK_MODE,
		VALLEY_MODE,
		PEAK_TO_PEAK_MODE
	} mode_t;

	// ----------------------------------------------------------------
	// apb carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [11:0] paddr;
		logic psel;
		logic penable;
		logic pwrite;
		logic [31:0] pwdata;
	} apb_req_t;

	typedef struct packed {
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} apb_rsp_t;

endpackage

// ### core/gate_delay.sv
`timescale 1ns/1ps
module gate_delay #(
	parameter int DLY_W = 14
) (
	// clock and control
	input wire logic ref_clk_i,
	input wire logic srst_i,
	input wire logic ce_i,
	// gate in and settings
	input wire logic gate_i,
	input wire logic tick_i,
	input wire logic pause_i,
	input wire logic [DLY_W-1:0] on_dly_i,
	input wire logic [DLY_W-1:0] off_dly_i,
	input wire logic bypass_on_i,
	input wire logic bypass_off_i,
	// delayed gate
	output logic gate_o,
	output logic pending_o
);

	typedef struct packed {
		logic target;
		logic out;
		logic [DLY_W-1:0] cnt;
	} dly_state_t;

	dly_state_t s;
	dly_state_t next_s;

	always_comb begin
		next_s = s;
		if (gate_i != s.target) begin
			// restart: the earlier pending change is dropped [R20]
			next_s.target = gate_i;
			next_s.cnt = '0;
		end else if (s.target != s.out) begin
			if ((s.target ? bypass_on_i : bypass_off_i) ||
			    (s.cnt >= (s.target ? on_dly_i : off_dly_i))) begin // [R19] [R21]
				next_s.out = s.target;
			end else if (tick_i && !pause_i) begin // [R23]
				next_s.cnt = s.cnt + 1'b1;
			end
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (srst_i) begin
			s <= '0;
		end else if (ce_i) begin
			s <= next_s;
		end
	end

	// first tick may be partial: delays are exact to within one tick
	assign gate_o = s.out;
	assign pending_o = s.target != s.out;

endmodule // gate_delay

// ### core/event_trigger_hold_control.sv
// Added by the designer: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`include "evt_defines.svh"
module event_trigger_hold_control #(
	parameter int SAMPLE_W = 24,
	parameter int DLY_W = 14,
	parameter int START_W = 10,
	parameter int TICK_CYCLES = `EVT_TICK_CYCLES
) (
	// clock, reset, enable
	input wire logic ref_clk_i,
	input wire logic srst_i,
	input wire logic ce_i,
	// register bus
	input wire evt_pkg::apb_req_t apb_req_i,
	output evt_pkg::apb_rsp_t apb_rsp_o,
	// contact inputs
	input wire logic gate_in_i,
	input wire logic freeze_in_i,
	input wire logic clear_in_i,
	input wire logic zero_req_in_i,
	input wire logic startup_pause_input_i,
	// measurement front end
	input wire logic signed [SAMPLE_W-1:0] sample_i,
	input wire logic sample_valid_i,
	input wire logic scale_err_i,
	// results and indicators
	output logic signed [SAMPLE_W-1:0] display_o,
	output logic signed [SAMPLE_W-1:0] dc_out_o,
	output logic has_data_o,
	output logic gate_active_indicator_o,
	output logic one_shot_o,
	output logic scale_err_ind_o
);

	localparam int TW = $clog2(TICK_CYCLES + 1);
	localparam logic [TW-1:0] TICK_LAST = TW'(TICK_CYCLES - 1);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [4:0] sync1;
		logic [4:0] sync2;
		logic gate_hold;
		logic dgate_prev;
		logic zero_prev;
		logic start_prev;
		evt_pkg::mode_t mode;
		logic neg_logic;
		logic [DLY_W-1:0] on_dly;
		logic [DLY_W-1:0] off_dly;
		logic [START_W-1:0] start_per;
		logic [START_W-1:0] start_cnt;
		logic [TW-1:0] tick_cnt;
		logic tick;
		logic has_data;
		logic zero_on;
		logic rise_err;
		logic win_bad;
		logic trk_seen;
		logic signed [SAMPLE_W-1:0] result;
		logic signed [SAMPLE_W-1:0] zero_ref;
		logic signed [SAMPLE_W-1:0] max_v;
		logic signed [SAMPLE_W-1:0] min_v;
		logic signed [SAMPLE_W-1:0] trk_max;
		logic signed [SAMPLE_W-1:0] trk_min;
		logic signed [SAMPLE_W-1:0] display;
		logic gate_ind;
		logic one_shot;
		logic err_ind;
		evt_pkg::apb_rsp_t rsp;
	} state_t;

	state_t s;
	state_t next_s;

	logic dgate;
	logic pending;
	logic pause;
	logic bypass_on;
	logic bypass_off;

	// sign-extends a sample into a bus word; SAMPLE_W must stay below 32
	function automatic logic [31:0] sext(input logic signed [SAMPLE_W-1:0] v);
		sext = {{(32 - SAMPLE_W){v[SAMPLE_W-1]}}, v};
	endfunction

	// ----------------------------------------------------------------
	// gate delay
	// ----------------------------------------------------------------
	assign pause = s.start_cnt != '0;
	assign bypass_on = s.mode == evt_pkg::CONTINUOUS_MODE; // [R21]
	assign bypass_off = (s.mode == evt_pkg::CONTINUOUS_MODE) ||
	                    (s.mode == evt_pkg::SAMPLE_ON_FALL_MODE); // [R21]

	gate_delay #(
		.DLY_W(DLY_W)
	) u_gate_delay (
		.ref_clk_i(ref_clk_i),
		.srst_i(srst_i),
		.ce_i(ce_i),
		.gate_i(s.gate_hold),
		.tick_i(s.tick),
		.pause_i(pause),
		.on_dly_i(s.on_dly),
		.off_dly_i(s.off_dly),
		.bypass_on_i(bypass_on),
		.bypass_off_i(bypass_off),
		.gate_o(dgate),
		.pending_o(pending)
	);

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		logic [4:0] lvl;
		logic gate_l;
		logic freeze_l;
		logic clear_l;
		logic zero_l;
		logic start_l;
		logic freeze_eff;
		logic d_rise;
		logic d_fall;
		logic setup;
		logic access;
		logic mapped;
		logic [31:0] rdata;
		logic signed [SAMPLE_W-1:0] shown;

		next_s = s;
		lvl = '0;
		gate_l = 1'b0;
		freeze_l = 1'b0;
		clear_l = 1'b0;
		zero_l = 1'b0;
		start_l = 1'b0;
		freeze_eff = 1'b0;
		d_rise = 1'b0;
		d_fall = 1'b0;
		setup = 1'b0;
		access = 1'b0;
		mapped = 1'b0;
		rdata = '0;
		shown = '0;

		// contacts: two stages, then polarity [R24]
		next_s.sync1 = {startup_pause_input_i, zero_req_in_i, clear_in_i, freeze_in_i,
		                gate_in_i};
		next_s.sync2 = s.sync1;
		lvl = s.sync2 ^ {5{s.neg_logic}}; // [R2]
		gate_l = lvl[0];
		freeze_l = lvl[1];
		clear_l = lvl[2];
		zero_l = lvl[3];
		start_l = lvl[4];
		freeze_eff = freeze_l && !clear_l; // [R13]

		// 0.1 s tick [R24]
		next_s.tick = 1'b0;
		if (s.tick_cnt == TICK_LAST) begin
			next_s.tick_cnt = '0;
			next_s.tick = 1'b1;
		end else begin
			next_s.tick_cnt = s.tick_cnt + 1'b1;
		end

		// gate reaches the delay only when neither freeze nor clear [R4] [R7]
		if (!freeze_eff && !clear_l) begin
			next_s.gate_hold = gate_l;
		end
		next_s.gate_ind = gate_l; // [R12]

		// startup pause, armed only while a delay is counting [R23]
		next_s.start_prev = start_l;
		if (start_l && !s.start_prev && !freeze_eff && pending &&
		    (s.start_per != '0)) begin
			next_s.start_cnt = s.start_per;
		end else if (pause && s.tick) begin
			next_s.start_cnt = s.start_cnt - 1'b1;
		end

		// measurement
		next_s.dgate_prev = dgate;
		d_rise = dgate && !s.dgate_prev;
		d_fall = !dgate && s.dgate_prev;
		next_s.one_shot = 1'b0;
		if (clear_l) begin
			// zero reference is kept, extremes cleared unconditionally [R7] [R17]
			next_s.has_data = 1'b0;
			next_s.result = '0;
			next_s.max_v = '0;
			next_s.min_v = '0;
			next_s.trk_seen = 1'b0;
			next_s.win_bad = 1'b1;
			next_s.rise_err = 1'b1;
		end else begin
			case (s.mode)
				evt_pkg::CONTINUOUS_MODE: begin
					// gate plays no part here [R1]
					if (sample_valid_i) begin
						next_s.result = sample_i;
						next_s.has_data = 1'b1;
						if (!s.has_data || sample_i > s.max_v) next_s.max_v = sample_i;
						if (!s.has_data || sample_i < s.min_v) next_s.min_v = sample_i;
					end
				end
				evt_pkg::SAMPLE_ON_FALL_MODE: begin
					if (d_rise) begin
						next_s.rise_err = scale_err_i; // [R5]
					end
					if (d_fall && !s.rise_err && !scale_err_i) begin // [R3] [R5]
						next_s.result = sample_i;
						next_s.has_data = 1'b1;
						next_s.one_shot = 1'b1; // [R14]
						if (!s.has_data || sample_i > s.max_v) begin // [R18]
							next_s.max_v = sample_i;
						end
						if (!s.has_data || sample_i < s.min_v) begin // [R18]
							next_s.min_v = sample_i;
						end
					end
				end
				evt_pkg::PEAK_MODE,
				evt_pkg::VALLEY_MODE,
				evt_pkg::PEAK_TO_PEAK_MODE: begin
					if (d_rise) begin
						next_s.trk_seen = 1'b0;
						next_s.win_bad = scale_err_i; // [R6]
					end
					if (dgate && scale_err_i) begin
						next_s.win_bad = 1'b1; // [R6]
					end else if (dgate && sample_valid_i) begin
						next_s.trk_seen = 1'b1;
						if (!s.trk_seen || d_rise || sample_i > s.trk_max) begin // [R9]
							next_s.trk_max = sample_i;
						end
						if (!s.trk_seen || d_rise || sample_i < s.trk_min) begin // [R10]
							next_s.trk_min = sample_i;
						end
						if (!s.has_data || sample_i > s.max_v) next_s.max_v = sample_i;
						if (!s.has_data || sample_i < s.min_v) next_s.min_v = sample_i;
					end
					if (d_fall && !s.win_bad && s.trk_seen) begin
						next_s.has_data = 1'b1;
						next_s.one_shot = 1'b1; // [R14]
						if (s.mode == evt_pkg::PEAK_MODE) begin
							next_s.result = s.trk_max; // [R9]
						end else if (s.mode == evt_pkg::VALLEY_MODE) begin
							next_s.result = s.trk_min; // [R10]
						end else begin
							next_s.result = s.trk_max - s.trk_min; // [R11]
						end
					end
				end
				default: begin
					next_s.result = s.result;
				end
			endcase
		end

		// zero request: no lockout gating at all [R15], but refused here [R16]
		next_s.zero_prev = zero_l;
		if (zero_l && !s.zero_prev && !freeze_eff && !clear_l && !scale_err_i &&
		    s.has_data) begin
			next_s.zero_on = !s.zero_on;
			next_s.zero_ref = s.result;
		end

		// display and analogue output; freeze holds the last shown value [R4]
		// built from the next state so display never lags has_data by a cycle
		shown = next_s.zero_on ? (next_s.result - next_s.zero_ref) : next_s.result;
		if (!freeze_eff) begin
			next_s.display = next_s.has_data ? shown : '0; // [R8]
			next_s.err_ind = scale_err_i;
		end

		// apb slave: one access cycle, answer registered at setup
		setup = apb_req_i.psel && !apb_req_i.penable;
		access = apb_req_i.psel && apb_req_i.penable && s.rsp.pready;
		mapped = 1'b1;
		case (apb_req_i.paddr)
			`EVT_OFS_CTRL: begin
				rdata[`EVT_CTRL_MODE_MSB:`EVT_CTRL_MODE_LSB] = s.mode;
				rdata[`EVT_CTRL_NEG_BIT] = s.neg_logic;
			end
			`EVT_OFS_ON_DLY: rdata[DLY_W-1:0] = s.on_dly;
			`EVT_OFS_OFF_DLY: rdata[DLY_W-1:0] = s.off_dly;
			`EVT_OFS_STARTUP: rdata[START_W-1:0] = s.start_per;
			`EVT_OFS_STATUS: begin
				rdata[`EVT_ST_HAS_DATA] = s.has_data;
				rdata[`EVT_ST_GATE] = s.gate_ind;
				rdata[`EVT_ST_ZERO_ON] = s.zero_on;
				rdata[`EVT_ST_FREEZE] = freeze_eff;
				rdata[`EVT_ST_CLEAR] = clear_l;
				rdata[`EVT_ST_SCALE_ERR] = s.err_ind;
				rdata[`EVT_ST_PENDING] = pending;
				rdata[`EVT_ST_PAUSE] = pause;
			end
			`EVT_OFS_RESULT: rdata = sext(s.display);
			`EVT_OFS_MAX: rdata = sext(s.max_v);
			`EVT_OFS_MIN: rdata = sext(s.min_v);
			`EVT_OFS_ZERO_REF: rdata = sext(s.zero_ref);
			default: mapped = 1'b0;
		endcase
		next_s.rsp.pready = setup;
		if (setup) begin
			next_s.rsp.prdata = apb_req_i.pwrite ? 32'h0000_0000 : rdata;
			next_s.rsp.pslverr = !mapped;
		end
		if (access && apb_req_i.pwrite && !s.rsp.pslverr) begin
			case (apb_req_i.paddr)
				`EVT_OFS_CTRL: begin
					// out-of-range mode codes are dropped, old mode kept [R1]
					if (apb_req_i.pwdata[`EVT_CTRL_MODE_MSB:`EVT_CTRL_MODE_LSB] <= 3'h4) begin
						next_s.mode = evt_pkg::mode_t'(
							apb_req_i.pwdata[`EVT_CTRL_MODE_MSB:`EVT_CTRL_MODE_LSB]);
					end
					next_s.neg_logic = apb_req_i.pwdata[`EVT_CTRL_NEG_BIT]; // [R2]
				end
				`EVT_OFS_ON_DLY: begin // [R19]
					next_s.on_dly = (apb_req_i.pwdata[DLY_W-1:0] > `EVT_DLY_MAX) ?
					                `EVT_DLY_MAX : apb_req_i.pwdata[DLY_W-1:0];
				end
				`EVT_OFS_OFF_DLY: begin // [R19]
					next_s.off_dly = (apb_req_i.pwdata[DLY_W-1:0] > `EVT_DLY_MAX) ?
					                 `EVT_DLY_MAX : apb_req_i.pwdata[DLY_W-1:0];
				end
				`EVT_OFS_STARTUP: begin // [R23]
					next_s.start_per = (apb_req_i.pwdata[START_W-1:0] > `EVT_STARTUP_MAX) ?
					                   `EVT_STARTUP_MAX : apb_req_i.pwdata[START_W-1:0];
				end
				default: begin
					next_s.start_per = s.start_per;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk_i) begin
		if (srst_i) begin
			s <= '0;
			s.neg_logic <= `EVT_NEG_RST;
			s.on_dly <= `EVT_DLY_RST;
			s.off_dly <= `EVT_DLY_RST;
			s.start_per <= `EVT_STARTUP_RST;
		end else if (ce_i) begin
			s <= next_s;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign apb_rsp_o = s.rsp;
	assign display_o = s.display;
	assign dc_out_o = s.display; // [R8]
	assign has_data_o = s.has_data;
	assign gate_active_indicator_o = s.gate_ind;
	assign one_shot_o = s.one_shot;
	assign scale_err_ind_o = s.err_ind;

endmodule // event_trigger_hold_control

// ### tb/evt_properties.sv
`timescale 1ns/1ps
module evt_properties #(
	parameter int SAMPLE_W = 24
) (
	// clock and reset
	input wire logic ref_clk_i,
	input wire logic srst_i,
	// register bus
	input wire evt_pkg::apb_req_t apb_req_i,
	input wire evt_pkg::apb_rsp_t apb_rsp_o,
	// contacts
	input wire logic gate_in_i,
	input wire logic freeze_in_i,
	input wire logic clear_in_i,
	// results
	input wire logic signed [SAMPLE_W-1:0] display_o,
	input wire logic signed [SAMPLE_W-1:0] dc_out_o,
	input wire logic has_data_o,
	input wire logic gate_active_indicator_o,
	input wire logic one_shot_o
);
	// --------
	// shadow of polarity and mode, taken at the write edge
	// --------
	logic neg_q;
	logic [2:0] mode_q;
	logic setup, mapped, g, fr, cl;
	assign setup = apb_req_i.psel && !apb_req_i.penable;
	assign mapped = apb_req_i.paddr[1:0] == 2'h0 && apb_req_i.paddr <= 12'h020;
	assign g = gate_in_i ^ neg_q;
	assign fr = freeze_in_i ^ neg_q;
	assign cl = clear_in_i ^ neg_q;
	always_ff @(posedge ref_clk_i) begin
		if (srst_i) begin
			neg_q <= 1'b0;
			mode_q <= 3'h0;
		end else if (apb_req_i.psel && apb_req_i.penable && apb_rsp_o.pready
				&& apb_req_i.pwrite && apb_req_i.paddr == 12'h000) begin
			neg_q <= apb_req_i.pwdata[3];
			// codes above four are refused by the block
			if (apb_req_i.pwdata[2:0] < 3'h5) begin
				mode_q <= apb_req_i.pwdata[2:0];
			end
		end
	end
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (srst_i);
	// --------
	// assertions
	// --------
	reset_quiet_a: assert property ($past(srst_i) |-> !has_data_o && display_o == '0)
		else $error("outputs busy after reset");
	dc_follow_a: assert property (dc_out_o == display_o)
		else $error("dc output differs");
	nodata_zero_a: assert property (!has_data_o |-> display_o == '0)
		else $error("display without data");
	shot_single_a: assert property (one_shot_o |=> !one_shot_o)
		else $error("one-shot too long");
	cont_quiet_a: assert property ((mode_q == 3'h0) [*8] |-> !one_shot_o)
		else $error("pulse in continuous mode");
	ready_next_a: assert property (setup |=> apb_rsp_o.pready ##1 !apb_rsp_o.pready)
		else $error("pready timing");
	bad_addr_a: assert property (setup && !mapped |=> apb_rsp_o.pslverr && apb_rsp_o.prdata == '0)
		else $error("unmapped access not refused");
	ind_on_a: assert property (g [*5] |-> gate_active_indicator_o)
		else $error("gate indicator dark");
	clear_empty_a: assert property (cl [*6] |-> !has_data_o)
		else $error("data kept under clear");
	freeze_hold_a: assert property ((fr && !cl) [*6] |-> $stable(display_o))
		else $error("display moved under freeze");
	shot_c: cover property (one_shot_o);
	slverr_c: cover property (apb_rsp_o.pslverr);
	freeze_c: cover property ((fr && !cl) [*8]);
endmodule // evt_properties

bind event_trigger_hold_control evt_properties #(.SAMPLE_W(SAMPLE_W)) i_props (
	.ref_clk_i(ref_clk_i), .srst_i(srst_i), .apb_req_i(apb_req_i), .apb_rsp_o(apb_rsp_o),
	.gate_in_i(gate_in_i), .freeze_in_i(freeze_in_i), .clear_in_i(clear_in_i),
	.display_o(display_o), .dc_out_o(dc_out_o), .has_data_o(has_data_o),
	.gate_active_indicator_o(gate_active_indicator_o), .one_shot_o(one_shot_o));

// ### tb/contact_driver.sv
`timescale 1ns/1ps
module contact_driver (
	// logical levels: gate, freeze, clear, zero, startup
	input wire logic [4:0] level_i,
	input wire logic neg_i,
	// contact pins
	output logic [4:0] pin_o
);
	// negative logic drives an asserted contact low
	assign pin_o = level_i ^ {5{neg_i}};
endmodule // contact_driver

// ### tb/event_trigger_hold_control_bench.sv
`timescale 1ns/1ps
module event_trigger_hold_control_bench;
	// --------
	// stimulus and design
	// --------
	localparam int TICK = 8;
	logic ref_clk_i = 1'b0;
	logic srst_i = 1'b1;
	evt_pkg::apb_req_t req = '0;
	evt_pkg::apb_rsp_t rsp;
	logic [4:0] lvl = 5'h0;
	logic neg = 1'b0;
	logic [4:0] pin;
	logic signed [23:0] smp = 24'sh0;
	logic err = 1'b0;
	logic signed [23:0] disp, dc;
	logic hd, ind, shot, eind;
	logic [31:0] rdat;
	logic rerr;
	int mismatches = 0;
	int checks = 0;
	int shots = 0;
	int n;
	int ex [3] = '{40, -20, 60};
	always #2 ref_clk_i = ~ref_clk_i;
	event_trigger_hold_control #(.TICK_CYCLES(TICK)) i_dut (
		.ref_clk_i(ref_clk_i), .srst_i(srst_i), .ce_i(1'b1), .apb_req_i(req), .apb_rsp_o(rsp),
		.gate_in_i(pin[0]), .freeze_in_i(pin[1]), .clear_in_i(pin[2]),
		.zero_req_in_i(pin[3]), .startup_pause_input_i(pin[4]),
		.sample_i(smp), .sample_valid_i(1'b1), .scale_err_i(err),
		.display_o(disp), .dc_out_o(dc), .has_data_o(hd),
		.gate_active_indicator_o(ind), .one_shot_o(shot), .scale_err_ind_o(eind));
	contact_driver i_ctl (.level_i(lvl), .neg_i(neg), .pin_o(pin));
	// --------
	// tasks
	// --------
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	task automatic chk(input string w, input logic [31:0] e, input logic [31:0] got);
		checks++;
		if (got !== e) begin
			mismatches++;
			$display("ERROR %s expected %h seen %h", w, e, got);
		end
	endtask
	task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int k;
		k = 0;
		@(posedge ref_clk_i);
		req <= '{paddr: a, psel: 1'b1, penable: 1'b0, pwrite: wr, pwdata: d};
		@(posedge ref_clk_i);
		req.penable <= 1'b1;
		do begin
			@(posedge ref_clk_i);
			k++;
		end while (rsp.pready !== 1'b1 && k < 16);
		if (k >= 16) begin
			mismatches++;
			wrap_up();
		end
		rdat = rsp.prdata;
		rerr = rsp.pslverr;
		req <= '0;
	endtask
	task automatic rd(input string w, input logic [11:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		chk(w, e, rdat);
	endtask
	task automatic dsp(input int e);
		chk("display", 32'(e), 32'(disp));
	endtask
	task automatic step(input int c);
		repeat (c) begin
			@(posedge ref_clk_i);
			if (shot === 1'b1) shots++;
		end
	endtask
	// gate held high for hi cycles, then low for lo cycles
	task automatic pulse(input int hi, input int lo);
		lvl[0] <= 1'b1;
		step(hi);
		lvl[0] <= 1'b0;
		step(lo);
	endtask
	task automatic zpulse();
		lvl[3] <= 1'b1;
		step(6);
		lvl[3] <= 1'b0;
		step(6);
	endtask
	task automatic wait_shot(input int lim);
		n = 0;
		do begin
			@(posedge ref_clk_i);
			n++;
		end while (shot !== 1'b1 && n < lim);
		if (n >= lim) begin
			mismatches++;
			wrap_up();
		end
	endtask
	// --------
	// sequence
	// --------
	initial begin
		repeat (4) @(posedge ref_clk_i);
		srst_i <= 1'b0;
		rd("ctrl", 12'h000, 32'h0);
		rd("on delay", 12'h004, 32'h0);
		rd("startup", 12'h00c, 32'h0);
		rd("status", 12'h010, 32'h1);
		bus(1'b1, 12'h004, 32'hffff);
		rd("on clamp", 12'h004, 32'h270f);
		bus(1'b1, 12'h00c, 32'hffff);
		rd("startup clamp", 12'h00c, 32'h3e7);
		bus(1'b1, 12'h000, 32'h7);
		rd("bad mode", 12'h000, 32'h0);
		bus(1'b0, 12'h024, 32'h0);
		chk("slverr", 32'h1, 32'(rerr));
		bus(1'b1, 12'h004, 32'h0);
		bus(1'b1, 12'h00c, 32'h0);
		bus(1'b1, 12'h008, 32'h2);
		bus(1'b1, 12'h000, 32'h8);
		neg <= 1'b1;
		$display("registers done");
		// sample on fall, negative logic, off delay ignored
		bus(1'b1, 12'h000, 32'h9);
		// clear first so extremes from continuous sampling do not linger
		lvl[2] <= 1'b1;
		step(8);
		lvl[2] <= 1'b0;
		step(6);
		smp <= 24'sd100;
		lvl[0] <= 1'b1;
		step(10);
		smp <= 24'sd55;
		lvl[0] <= 1'b0;
		wait_shot(60);
		chk("off bypass", 32'h1, 32'(n <= 8));
		step(2);
		dsp(55);
		shots = 0;
		smp <= 24'sd70;
		pulse(10, 14);
		chk("shots", 32'h1, shots);
		rd("max", 12'h018, 32'd70);
		rd("min", 12'h01c, 32'd55);
		err <= 1'b1;
		lvl[0] <= 1'b1;
		step(6);
		chk("err ind", 32'h1, 32'(eind));
		chk("indicator", 32'h1, 32'(ind));
		err <= 1'b0;
		smp <= 24'sd90;
		pulse(6, 14);
		dsp(70);
		$display("fall mode done");
		// freeze, then clear on top of it
		lvl[1] <= 1'b1;
		step(4);
		smp <= 24'sd33;
		pulse(10, 14);
		dsp(70);
		zpulse();
		rd("status frz", 12'h010, 32'h9);
		lvl[2] <= 1'b1;
		step(8);
		chk("data", 32'h0, 32'(hd));
		rd("status clr", 12'h010, 32'h10);
		pulse(10, 14);
		chk("shots", 32'h1, shots);
		lvl[2:1] <= 2'h0;
		step(6);
		zpulse();
		rd("status empty", 12'h010, 32'h0);
		// zero reference across a clear
		smp <= 24'sd40;
		pulse(10, 14);
		dsp(40);
		zpulse();
		rd("status zero", 12'h010, 32'h5);
		dsp(0);
		lvl[2] <= 1'b1;
		step(8);
		lvl[2] <= 1'b0;
		step(6);
		rd("zero ref", 12'h020, 32'd40);
		rd("max clr", 12'h018, 32'h0);
		rd("min clr", 12'h01c, 32'h0);
		smp <= 24'sd45;
		pulse(10, 14);
		dsp(5);
		err <= 1'b1;
		step(4);
		zpulse();
		err <= 1'b0;
		step(4);
		rd("zero kept", 12'h010, 32'h5);
		zpulse();
		rd("zero off", 12'h010, 32'h1);
		$display("freeze clear zero done");
		// window modes: the middle sample is the maximum, the last sample the minimum, off delay 0
		bus(1'b1, 12'h008, 32'h0);
		for (int i = 0; i < 3; i++) begin
			bus(1'b1, 12'h000, 32'ha + 32'(i));
			shots = 0;
			smp <= 24'sd10;
			lvl[0] <= 1'b1;
			step(8);
			smp <= 24'sd40;
			step(4);
			smp <= -24'sd20;
			pulse(4, 14);
			chk("shots", 32'h1, shots);
			dsp(ex[i]);
		end
		shots = 0;
		smp <= 24'sd10;
		lvl[0] <= 1'b1;
		step(8);
		err <= 1'b1;
		step(3);
		err <= 1'b0;
		smp <= 24'sd90;
		pulse(4, 14);
		chk("shots", 32'h0, shots);
		dsp(60);
		$display("window modes done");
		// gate delays in peak mode, off delay two ticks
		bus(1'b1, 12'h000, 32'ha);
		bus(1'b1, 12'h008, 32'h2);
		smp <= 24'sd50;
		pulse(10, 0);
		wait_shot(80);
		chk("off delay", 32'h1, 32'(n >= 14 && n <= 30));
		step(4);
		shots = 0;
		pulse(10, 6);
		lvl[0] <= 1'b1;
		step(30);
		chk("abandoned", 32'h0, shots);
		lvl[0] <= 1'b0;
		step(40);
		chk("shots", 32'h1, shots);
		bus(1'b1, 12'h00c, 32'h2);
		pulse(10, 3);
		lvl[4] <= 1'b1;
		wait_shot(100);
		chk("paused", 32'h1, 32'(n + 3 >= 31 && n + 3 <= 47));
		lvl[4] <= 1'b0;
		step(4);
		$display("delays done");
		wrap_up();
	end
endmodule // event_trigger_hold_control_bench
